/* gpp_defs.svh */
// Purpose: constants for the four-port general purpose I/O block
// Assumes: register indices are Avalon word addresses (byte address = 4 x index)
// Notes: definitions only
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define GPP_IDX_P3_DATA 32'hFFFFF006
`define GPP_IDX_P4_DATA 32'hFFFFF008
`define GPP_IDX_P5_DATA 32'hFFFFF00A
`define GPP_IDX_P6_DATA 32'hFFFFF00C
`define GPP_IDX_P3_DIR 32'hFFFFF026
`define GPP_IDX_P4_DIR 32'hFFFFF028
`define GPP_IDX_P5_DIR 32'hFFFFF02A
`define GPP_IDX_P6_DIR 32'hFFFFF02C
`define GPP_IDX_P3_PU 32'hFFFFF0A6
`define GPP_IDX_MM 32'hFFFFF04C

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define GPP_RST_DATA8 8'h00
`define GPP_RST_DATA6 6'h00
`define GPP_RST_DIR8 8'hFF
`define GPP_RST_DIR6 6'h3F
`define GPP_RST_PU 8'h00
`define GPP_RST_MM 2'h0
`define GPP_MM_AD_BIT 0
`define GPP_MM_UA_BIT 1
`define GPP_TMR4_BIT 6
`define GPP_TMR5_BIT 7

// ----------------------------------------------------------------
// noise filter timing
// ----------------------------------------------------------------
`define GPP_CLK_PERIOD_NS 10
`define GPP_NF_TIME_NS 30
`define GPP_NF_CYCLES ((`GPP_NF_TIME_NS + `GPP_CLK_PERIOD_NS - 1) / `GPP_CLK_PERIOD_NS)

`endif

/* gpp_pkg.sv */
// Purpose: shared types for the four-port general purpose I/O block
// Assumes: constants come from gpp_defs.svh
// Notes: pins of ports 3..6 travel as one packed struct
package gpp_pkg;

  // ----------------------------------------------------------------
  // pin group, one bit per pad
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] p6;
    logic [7:0] p5;
    logic [7:0] p4;
    logic [7:0] p3;
  } gpp_pins_t;

  // bus answer sequencer
  typedef enum logic [0:0] {
    GPP_BUS_IDLE = 1'b0,
    GPP_BUS_ACK = 1'b1
  } gpp_bus_st_t;

  // ----------------------------------------------------------------
  // state of the port block, except the noise filters and boot_reg
  // ----------------------------------------------------------------
  typedef struct packed {
    gpp_bus_st_t bus_st;
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] p3;
    logic [7:0] p4;
    logic [7:0] p5;
    logic [5:0] p6;
    logic [7:0] dir3;
    logic [7:0] dir4;
    logic [7:0] dir5;
    logic [5:0] dir6;
    logic [7:0] pu3;
    logic [1:0] mm;
    gpp_pins_t sync1;
    gpp_pins_t sync2;
    gpp_pins_t pin_out;
    gpp_pins_t pin_oe_n;
    logic [7:0] pu_out;
    logic [15:0] ad_rd;
  } gpp_state_t;

  // noise filter state
  typedef struct packed {
    logic [1:0] cnt;
    logic level;
  } gpp_nf_state_t;

endpackage

/* gpp_noise_filter.sv */
// Purpose: digital noise filter for one timer input
// Assumes: sample_in is already synchronised to clk_in
// Notes: level follows the sample only after COUNT equal differing samples
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_noise_filter #(
  parameter logic [1:0] COUNT = 2'(`GPP_NF_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sample_in,
  output logic level_out
);
  import gpp_pkg::*;

  gpp_nf_state_t s_reg;
  gpp_nf_state_t s_next;

  // ----------------------------------------------------------------
  // counting of differing samples
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (sample_in == s_reg.level) begin
      s_next.cnt = 2'h0;
    end else if (s_reg.cnt == COUNT - 2'h1) begin
      s_next.cnt = 2'h0;
      s_next.level = sample_in;
    end else begin
      s_next.cnt = s_reg.cnt + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.level;

  // a change of level needs three equal samples before it
  AST_NF_STABLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(level_out) |-> ($past(sample_in, 1) == level_out)
      && ($past(sample_in, 2) == level_out) && ($past(sample_in, 3) == level_out))
    else $error("filtered level changed without stable input");

endmodule

/* gpp_ports.sv */
// Purpose: general purpose I/O for ports 3 to 6 with an Avalon-MM slave
// Assumes: pins arrive asynchronously; timer and bus controller share clk_in
// Notes: registers sit in data bits 7:0, upper bits read as zero
// Notes on behaviour
// - each port 3 direction bit selects output when 0 and input when 1.
// - reset sets all directions to input, port 3 to FFH and port 6 to 3FH.
// - an input bit reads the pin level and a write only changes the latch.
// - an output bit reads the latch and a written value goes to the pin.
// - port 3 pull-ups follow their select bits, which reset to 00H.
// - port 3 bits 6 and 7 reach the timers through a noise filter.
// - a port 3 pin drives the OR of its latch and the alternate output.
// - ports 4, 5 and 6 have no software pull-up.
// - port 4 and 5 data sit at FFFFF008H and FFFFF00AH and reset to 00H.
// - the mode register moves ports 4 and 5 to the bus, keeping directions.
// - port 6 has six bits, its top two data bits read 0, reset 00H.
// - the mode register moves port 6 to upper address lines, keeping direction.
// - direction and pull-up registers take byte accesses only; a bit changes by read-modify-write.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_ports (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire gpp_pkg::gpp_pins_t pins_in,
  output gpp_pkg::gpp_pins_t pins_out,
  output gpp_pkg::gpp_pins_t pins_oe_n_out,
  output logic [7:0] port3_pullup_en_out,
  input wire logic [7:0] timer_alt_output_in,
  output logic timer4_input_out,
  output logic timer5_input_out,
  input wire logic [15:0] multiplexed_address_data_lines_out_in,
  input wire logic multiplexed_address_data_lines_drive_in,
  output logic [15:0] multiplexed_address_data_lines_in_out,
  input wire logic [5:0] upper_address_lines_in,
  output logic [1:0] memory_expansion_mode_out
);
  import gpp_pkg::*;

  gpp_state_t s_reg;
  gpp_state_t s_next;
  logic req;
  logic wr_lo;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // input bits show the pin, output bits show the latch
  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] pin,
                                           input logic [7:0] dir);
    port_view = (dir & pin) | (~dir & latch);
  endfunction

  // byte lane 0 carries every register
  assign req = avs_read_in | avs_write_in;
  assign wr_lo = avs_write_in & avs_byteenable_in[0];

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (avs_address_in == `GPP_IDX_P3_DATA) begin
      rd_byte = port_view(s_reg.p3, s_reg.sync2.p3, s_reg.dir3);
    end else if (avs_address_in == `GPP_IDX_P4_DATA) begin
      rd_byte = port_view(s_reg.p4, s_reg.sync2.p4, s_reg.dir4);
    end else if (avs_address_in == `GPP_IDX_P5_DATA) begin
      rd_byte = port_view(s_reg.p5, s_reg.sync2.p5, s_reg.dir5);
    end else if (avs_address_in == `GPP_IDX_P6_DATA) begin
      rd_byte = port_view({2'h0, s_reg.p6}, {2'h0, s_reg.sync2.p6},
                          {2'h0, s_reg.dir6});
    end else if (avs_address_in == `GPP_IDX_P3_DIR) begin
      rd_byte = s_reg.dir3;
    end else if (avs_address_in == `GPP_IDX_P4_DIR) begin
      rd_byte = s_reg.dir4;
    end else if (avs_address_in == `GPP_IDX_P5_DIR) begin
      rd_byte = s_reg.dir5;
    end else if (avs_address_in == `GPP_IDX_P6_DIR) begin
      rd_byte = {2'h0, s_reg.dir6};
    end else if (avs_address_in == `GPP_IDX_P3_PU) begin
      rd_byte = s_reg.pu3;
    end else if (avs_address_in == `GPP_IDX_MM) begin
      rd_byte = {6'h00, s_reg.mm};
    end else begin
      rd_byte = 8'h00; // unmapped reads as zero
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // two-flop pin synchroniser
    s_next.sync1 = pins_in;
    s_next.sync2 = s_reg.sync1;

    // bus answer: one wait cycle, then accept
    s_next.waitreq = 1'b1;
    case (s_reg.bus_st)
      GPP_BUS_IDLE: begin
        if (req) begin
          s_next.bus_st = GPP_BUS_ACK;
          s_next.waitreq = 1'b0;
          s_next.rdata = {24'h000000, rd_byte};
        end
      end
      GPP_BUS_ACK: begin
        s_next.bus_st = GPP_BUS_IDLE;
        // write lands on the edge that sees waitrequest low
        if (wr_lo) begin
          if (avs_address_in == `GPP_IDX_P3_DATA) begin
            s_next.p3 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P4_DATA) begin
            s_next.p4 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P5_DATA) begin
            s_next.p5 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P6_DATA) begin
            s_next.p6 = avs_writedata_in[5:0];
          end else if (avs_address_in == `GPP_IDX_P3_DIR) begin
            s_next.dir3 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P4_DIR) begin
            s_next.dir4 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P5_DIR) begin
            s_next.dir5 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_P6_DIR) begin
            s_next.dir6 = avs_writedata_in[5:0];
          end else if (avs_address_in == `GPP_IDX_P3_PU) begin
            s_next.pu3 = avs_writedata_in[7:0];
          end else if (avs_address_in == `GPP_IDX_MM) begin
            s_next.mm = avs_writedata_in[1:0];
          end
        end
      end
      default: begin
        s_next.bus_st = GPP_BUS_IDLE;
      end
    endcase

    // port 3: latch ORed with alternate output, pull-ups on select
    s_next.pin_out.p3 = s_reg.p3 | timer_alt_output_in;
    s_next.pin_oe_n.p3 = s_reg.dir3;
    s_next.pu_out = s_reg.pu3;

    // ports 4 and 5: bus controller owns pins in expansion mode
    if (s_reg.mm[`GPP_MM_AD_BIT]) begin
      s_next.pin_out.p4 = multiplexed_address_data_lines_out_in[7:0];
      s_next.pin_out.p5 = multiplexed_address_data_lines_out_in[15:8];
      s_next.pin_oe_n.p4 = {8{~multiplexed_address_data_lines_drive_in}};
      s_next.pin_oe_n.p5 = {8{~multiplexed_address_data_lines_drive_in}};
    end else begin
      s_next.pin_out.p4 = s_reg.p4;
      s_next.pin_out.p5 = s_reg.p5;
      s_next.pin_oe_n.p4 = s_reg.dir4;
      s_next.pin_oe_n.p5 = s_reg.dir5;
    end

    // port 6: upper address lines in expansion mode
    if (s_reg.mm[`GPP_MM_UA_BIT]) begin
      s_next.pin_out.p6 = upper_address_lines_in;
      s_next.pin_oe_n.p6 = 6'h00;
    end else begin
      s_next.pin_out.p6 = s_reg.p6;
      s_next.pin_oe_n.p6 = s_reg.dir6;
    end

    // bus controller sees synchronised address/data pins
    s_next.ad_rd = {s_reg.sync2.p5, s_reg.sync2.p4};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg.bus_st <= GPP_BUS_IDLE;
      s_reg.waitreq <= 1'b1;
      s_reg.rdata <= 32'h00000000;
      s_reg.p3 <= `GPP_RST_DATA8;
      s_reg.p4 <= `GPP_RST_DATA8;
      s_reg.p5 <= `GPP_RST_DATA8;
      s_reg.p6 <= `GPP_RST_DATA6;
      s_reg.dir3 <= `GPP_RST_DIR8;
      s_reg.dir4 <= `GPP_RST_DIR8;
      s_reg.dir5 <= `GPP_RST_DIR8;
      s_reg.dir6 <= `GPP_RST_DIR6;
      s_reg.pu3 <= `GPP_RST_PU;
      s_reg.mm <= `GPP_RST_MM;
      s_reg.sync1 <= '0;
      s_reg.sync2 <= '0;
      s_reg.pin_out <= '0;
      s_reg.pin_oe_n <= '1;
      s_reg.pu_out <= `GPP_RST_PU;
      s_reg.ad_rd <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // timer input filters
  // ----------------------------------------------------------------
  gpp_noise_filter u_nf_tmr4 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sample_in(s_reg.sync2.p3[`GPP_TMR4_BIT]),
    .level_out(timer4_input_out)
  );

  gpp_noise_filter u_nf_tmr5 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sample_in(s_reg.sync2.p3[`GPP_TMR5_BIT]),
    .level_out(timer5_input_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_out = s_reg.rdata;
  assign avs_waitrequest_out = s_reg.waitreq;
  assign pins_out = s_reg.pin_out;
  assign pins_oe_n_out = s_reg.pin_oe_n;
  assign port3_pullup_en_out = s_reg.pu_out; // pull-ups only on port 3
  assign multiplexed_address_data_lines_in_out = s_reg.ad_rd;
  assign memory_expansion_mode_out = s_reg.mm;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic boot_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  sequence acc_wr(logic [31:0] a);
    s_reg.bus_st == GPP_BUS_ACK && wr_lo && avs_address_in == a;
  endsequence

  sequence acc_rd(logic [31:0] a);
    s_reg.bus_st == GPP_BUS_IDLE && avs_read_in && avs_address_in == a;
  endsequence

  AST_RESET_INPUT: assert property (boot_reg |->
    s_reg.dir3 == 8'hFF && s_reg.dir6 == 6'h3F && pins_oe_n_out == '1)
    else $error("ports not all input after reset");

  AST_DIR_TO_OE: assert property (acc_wr(`GPP_IDX_P3_DIR) |->
    ##2 pins_oe_n_out.p3 == $past(avs_writedata_in[7:0], 2))
    else $error("port 3 enable does not follow direction write");

  AST_READ_PIN: assert property (acc_rd(`GPP_IDX_P4_DATA)
    && s_reg.dir4 == 8'hFF |-> ##1 avs_readdata_out[7:0] == $past(s_reg.sync2.p4))
    else $error("input bit read does not return pin level");

  AST_WRITE_DRIVES: assert property (acc_wr(`GPP_IDX_P5_DATA)
    && s_reg.dir5 == 8'h00 && !s_reg.mm[0] |->
    ##2 pins_out.p5 == $past(avs_writedata_in[7:0], 2) && pins_oe_n_out.p5 == 8'h00)
    else $error("written output value not driven");

  AST_PULLUP: assert property (acc_wr(`GPP_IDX_P3_PU) |->
    ##2 port3_pullup_en_out == $past(avs_writedata_in[7:0], 2))
    else $error("pull-up enable does not follow select");

  AST_OR_DRIVE: assert property (##1 pins_out.p3 ==
    ($past(s_reg.p3) | $past(timer_alt_output_in)))
    else $error("port 3 pin is not latch OR alternate output");

  AST_P6_TOP_ZERO: assert property (acc_rd(`GPP_IDX_P6_DATA) |->
    ##1 avs_readdata_out[7:6] == 2'h0 && !avs_waitrequest_out)
    else $error("port 6 top bits read nonzero");

  AST_MM_KEEPS_DIR: assert property (acc_wr(`GPP_IDX_MM) |->
    ##1 $stable(s_reg.dir4) && $stable(s_reg.dir5) && $stable(s_reg.dir6))
    else $error("mode write changed a direction register");

  AST_BUS_OWNS: assert property (s_reg.mm[0] |->
    ##1 pins_oe_n_out.p4 == {8{~$past(multiplexed_address_data_lines_drive_in)}})
    else $error("bus controller does not own port 4 drive");

  AST_UA_OWNS: assert property (s_reg.mm[1] |->
    ##1 pins_out.p6 == $past(upper_address_lines_in) && pins_oe_n_out.p6 == 6'h00)
    else $error("upper address lines not driven on port 6");

  AST_ONE_WAIT: assert property (s_reg.bus_st == GPP_BUS_IDLE && req |->
    ##1 !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not after exactly one wait cycle");

endmodule

/* gpp_pad_model.sv */
// Purpose: pad and far-side model for the four-port I/O block
// Assumes: pad levels settle within the cycle; bench sets external drive
// Notes: undriven pads without pull-up toggle every cycle, never hold a value
`timescale 1ns/1ps
module gpp_pad_model (
  input wire logic clk_in,
  input wire gpp_pkg::gpp_pins_t pins_out_in,
  input wire gpp_pkg::gpp_pins_t pins_oe_n_in,
  input wire logic [7:0] pullup_en_in,
  input wire gpp_pkg::gpp_pins_t ext_en_in,
  input wire gpp_pkg::gpp_pins_t ext_lvl_in,
  output gpp_pkg::gpp_pins_t pins_in_out
);
  import gpp_pkg::*;

  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  gpp_pins_t float_reg = 30'h15555555;
  gpp_pins_t pull_vec;

  // floating level changes each cycle so no stale value survives
  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end

  // pull-ups only exist on port 3 pads
  assign pull_vec = {22'h000000, pullup_en_in};

  // device drive wins, then external drive, then pull-up or float
  assign pins_in_out = (~pins_oe_n_in & pins_out_in)
    | (pins_oe_n_in & ext_en_in & ext_lvl_in)
    | (pins_oe_n_in & ~ext_en_in & (pull_vec | float_reg));
endmodule

/* tb.sv */
// Purpose: self-checking bench for the four-port I/O block
// Assumes: Avalon word address equals register index
// Notes: pads resolved by gpp_pad_model; bus controller driven here
`timescale 1ns/1ps
`include "gpp_defs.svh"
module tb;
  import gpp_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] avs_address_in = 32'h00000000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [3:0] avs_byteenable_in = 4'h1;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  gpp_pins_t pins_in, pins_out, pins_oe_n_out;
  gpp_pins_t ext_en = 30'h3FFFFFFF;
  gpp_pins_t ext_lvl = 30'h00000000;
  logic [7:0] port3_pullup_en_out;
  logic [7:0] timer_alt = 8'h00;
  logic timer4_input_out, timer5_input_out;
  logic [15:0] ad_out = 16'h0000;
  logic ad_drive = 1'b0;
  logic [15:0] ad_in_out;
  logic [5:0] ua = 6'h00;
  logic [1:0] mm_out;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] rd_val;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  gpp_ports i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins_in),
    .pins_out(pins_out), .pins_oe_n_out(pins_oe_n_out),
    .port3_pullup_en_out(port3_pullup_en_out), .timer_alt_output_in(timer_alt),
    .timer4_input_out(timer4_input_out), .timer5_input_out(timer5_input_out),
    .multiplexed_address_data_lines_out_in(ad_out),
    .multiplexed_address_data_lines_drive_in(ad_drive),
    .multiplexed_address_data_lines_in_out(ad_in_out),
    .upper_address_lines_in(ua), .memory_expansion_mode_out(mm_out)
  );

  gpp_pad_model i_pads (
    .clk_in(clk_in), .pins_out_in(pins_out), .pins_oe_n_in(pins_oe_n_out),
    .pullup_en_in(port3_pullup_en_out), .ext_en_in(ext_en),
    .ext_lvl_in(ext_lvl), .pins_in_out(pins_in)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one Avalon transfer, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [31:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_byteenable_in <= be;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) n_fail++;
    rd_val = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'h1);
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, a, 8'h00, 4'h1);
    chk(name, rd_val, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // watchdog, far beyond the expected run
  initial begin
    idle(20000);
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(12);
    rst_n_in <= 1'b1;
    // reset values
    rchk("dir3 reset", 32'hFFFFF026, 32'h000000FF);
    rchk("dir4 reset", `GPP_IDX_P4_DIR, 32'h000000FF);
    rchk("dir6 reset", 32'hFFFFF02C, 32'h0000003F);
    rchk("pu3 reset", 32'hFFFFF0A6, 32'h00000000);
    rchk("p4 pin read", `GPP_IDX_P4_DATA, 32'h00000000);
    chk("oe_n reset", {2'b00, pins_oe_n_out}, 32'h3FFFFFFF);
    chk("pullup reset", {24'h0, port3_pullup_en_out}, 32'h00000000);
    // input mode reads pin, write touches latch only
    ext_lvl.p3 <= 8'hA5;
    idle(4);
    rchk("p3 pin read", `GPP_IDX_P3_DATA, 32'h000000A5);
    wr(`GPP_IDX_P3_DATA, 8'h3C);
    idle(2);
    chk("p3 oe_n input", {24'h0, pins_oe_n_out.p3}, 32'h000000FF);
    rchk("p3 read after write", `GPP_IDX_P3_DATA, 32'h000000A5);
    // mixed directions
    wr(32'hFFFFF026, 8'h0F);
    idle(2);
    chk("p3 oe_n mixed", {24'h0, pins_oe_n_out.p3}, 32'h0000000F);
    chk("p3 out mixed", {24'h0, pins_out.p3 & 8'hF0}, 32'h00000030);
    rchk("p3 mixed read", `GPP_IDX_P3_DATA, 32'h00000035);
    // bit access as read-modify-write, refused accesses
    acc(1'b0, 32'hFFFFF026, 8'h00, 4'h1);
    wr(32'hFFFFF026, rd_val[7:0] | 8'h80);
    rchk("dir3 bit set", 32'hFFFFF026, 32'h0000008F);
    acc(1'b1, 32'hFFFFF026, 8'h00, 4'h0);
    rchk("dir3 no byteenable", 32'hFFFFF026, 32'h0000008F);
    wr(32'hFFFFF0F0, 8'h55);
    rchk("unmapped read", 32'hFFFFF0F0, 32'h00000000);
    // alternate output ORed with latch
    wr(`GPP_IDX_P3_DATA, 8'h00);
    wr(32'hFFFFF026, 8'h00);
    timer_alt <= 8'h81;
    idle(3);
    chk("p3 alt only", {24'h0, pins_out.p3}, 32'h00000081);
    wr(`GPP_IDX_P3_DATA, 8'h3C);
    idle(2);
    chk("p3 alt or latch", {24'h0, pins_out.p3}, 32'h000000BD);
    timer_alt <= 8'h00;
    // pull-ups on released pads
    wr(32'hFFFFF026, 8'hFF);
    wr(32'hFFFFF0A6, 8'hF0);
    idle(2);
    chk("pullup enables", {24'h0, port3_pullup_en_out}, 32'h000000F0);
    ext_en.p3 <= 8'h00;
    idle(4);
    acc(1'b0, `GPP_IDX_P3_DATA, 8'h00, 4'h1);
    chk("pulled pins", rd_val & 32'h000000F0, 32'h000000F0);
    ext_en.p3 <= 8'hFF;
    // timer noise filter
    ext_lvl.p3 <= 8'h00;
    idle(10);
    ext_lvl.p3[6] <= 1'b1;
    idle(3);
    chk("timer4 early", {31'h0, timer4_input_out}, 32'h00000000);
    idle(6);
    chk("timer4 settled", {31'h0, timer4_input_out}, 32'h00000001);
    ext_lvl.p3[7] <= 1'b1;
    idle(1);
    ext_lvl.p3[7] <= 1'b0;
    idle(10);
    chk("timer5 glitch", {31'h0, timer5_input_out}, 32'h00000000);
    // port 6 six bits
    wr(32'hFFFFF02C, 8'h00);
    wr(32'hFFFFF00C, 8'hFF);
    idle(2);
    chk("p6 out", {26'h0, pins_out.p6}, 32'h0000003F);
    chk("p6 oe_n", {26'h0, pins_oe_n_out.p6}, 32'h00000000);
    rchk("p6 read", 32'hFFFFF00C, 32'h0000003F);
    // ports 4 and 5 latches
    wr(`GPP_IDX_P4_DIR, 8'h00);
    rchk("p4 latch reset", 32'hFFFFF008, 32'h00000000);
    wr(`GPP_IDX_P5_DIR, 8'h00);
    rchk("p5 latch reset", 32'hFFFFF00A, 32'h00000000);
    wr(32'hFFFFF008, 8'h5A);
    wr(32'hFFFFF00A, 8'hC3);
    idle(2);
    chk("p5 p4 out", {16'h0, pins_out.p5, pins_out.p4}, 32'h0000C35A);
    // multiplexed bus mode
    wr(`GPP_IDX_MM, 8'h01);
    ad_out <= 16'h1234;
    ad_drive <= 1'b1;
    idle(3);
    chk("mode out", {30'h0, mm_out}, 32'h00000001);
    chk("ad drive", {16'h0, pins_out.p5, pins_out.p4}, 32'h00001234);
    ad_drive <= 1'b0;
    ext_lvl.p4 <= 8'h9C;
    ext_lvl.p5 <= 8'hE7;
    idle(5);
    chk("ad release", {16'h0, pins_oe_n_out.p5, pins_oe_n_out.p4}, 32'h0000FFFF);
    chk("ad sample", {16'h0, ad_in_out}, 32'h0000E79C);
    rchk("dir4 kept", `GPP_IDX_P4_DIR, 32'h00000000);
    rchk("dir5 kept", `GPP_IDX_P5_DIR, 32'h00000000);
    // upper address mode
    ua <= 6'h2A;
    wr(`GPP_IDX_MM, 8'h03);
    idle(3);
    chk("ua out", {26'h0, pins_out.p6}, 32'h0000002A);
    wr(32'hFFFFF02C, 8'h3F);
    idle(2);
    chk("ua oe_n", {26'h0, pins_oe_n_out.p6}, 32'h00000000);
    rchk("dir6 stored", 32'hFFFFF02C, 32'h0000003F);
    wr(`GPP_IDX_MM, 8'h00);
    idle(3);
    chk("p6 port again", {26'h0, pins_oe_n_out.p6}, 32'h0000003F);
    chk("p4 port again", {24'h0, pins_out.p4}, 32'h0000005A);
    report_and_stop();
  end
endmodule
